// [common/sgi_if.sv]
// register, freeze and interrupt acknowledge link between core and module
`timescale 1ns/1ns
`default_nettype none
interface sgi_if;
  // register access
  logic sel;
  logic wr;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  // debug freeze
  logic freeze;
  // interrupt requests and acknowledge
  logic [7:1] irq_req;
  logic iack;
  logic [2:0] iack_level;
  logic [2:0] iack_mask;
  logic arb_out;
  logic arb_bus;
  logic vec_valid;
  logic [7:0] vector;
  modport dev (input sel, wr, addr, wdata, freeze, iack, iack_level, iack_mask, arb_bus,
               output rdata, ack, irq_req, arb_out, vec_valid, vector);
  modport host (output sel, wr, addr, wdata, freeze, iack, iack_level, iack_mask, arb_bus,
                input rdata, ack, irq_req, arb_out, vec_valid, vector);
endinterface : sgi_if
`default_nettype wire

// [common/sgi_pkg.sv]
// constants shared by both ends of the serial module global control link
//
// Contract
// RULE1 - stop bit gates the whole module's clock; the code holds the pins and masks requests, halt and acknowledge instead
// RULE2 - while stopped only the config register reads
// RULE3 - writes are stored even while stopped
// RULE4 - stop set by software write and reset
// RULE5 - software quiesces units before setting stop
// RULE6 - freeze with upper bit halts queued unit
// RULE7 - system asserts freeze in background debug
// RULE8 - level field picks request line seven to one
// RULE9 - level zero disables that unit's requests
// RULE10 - equal levels: queued unit served first
// RULE11 - acknowledge mask compared with request level
// RULE12 - serial arbitration; zero number means spurious
// RULE13 - winner drives vector on data bus
// RULE14 - vector upper bits shared, bit zero names source
// RULE15 - vector resets 0x0f, bit zero reads one
// RULE16 - assign bit: clear general purpose, set queued
// RULE17 - direction bit: clear input, set output
// RULE18 - transmit enabled forces transmit pin output
// RULE19 - data register drives outputs, reads pin levels
// RULE20 - software loads data before setting direction
// RULE21 - data pin roles follow direction and mode
// RULE22 - select pins roles follow direction and mode
// RULE23 - clock and transmit pins stay general otherwise
`default_nettype none
package sgi_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PIN_COUNT = 8;
  localparam int LEVEL_W = 3;
  localparam int ARB_W = 4;
  // register indices
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_LEVEL = 4'h1;
  localparam logic [ADDR_W-1:0] REG_VECTOR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PORT_DATA = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PIN_ASSIGN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DIRECTION = 4'h5;
  // module_config_reg fields
  localparam int CFG_STOP_BIT = 7;
  localparam int CFG_FRZ1_BIT = 6;
  localparam int CFG_FRZ0_BIT = 5;
  localparam int CFG_ARB_LSB = 0;
  // irq_level_reg fields
  localparam int LVL_QUEUED_LSB = 3;
  localparam int LVL_ASYNC_LSB = 0;
  // reset values
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h80;
  localparam logic [DATA_W-1:0] LEVEL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h0f;
  localparam logic [DATA_W-1:0] PORT_DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PIN_ASSIGN_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DIRECTION_RESET = 8'h00;
  // pin positions
  localparam int PIN_MISO = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_SEL0 = 3;
  localparam int PIN_TXD = 7;
  // host waits this count plus one cycles for a vector before calling it spurious
  localparam logic [3:0] IACK_TIMEOUT = 4'h9;
endpackage : sgi_pkg
`default_nettype wire

// [hdl/sgi_device.sv]
// module end: global config, interrupt levels, vector answer and pin control
`timescale 1ns/1ns
`default_nettype none
module sgi_device (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // link to the core
  sgi_if.dev bus,
  // serial units
  input wire logic queued_irq_req,
  input wire logic async_irq_req,
  input wire logic queued_unit_enable,
  input wire logic async_tx_enable,
  input wire logic master_mode,
  input wire logic transfer_boundary,
  input wire logic txd_data,
  input wire logic [sgi_pkg::PIN_COUNT-2:0] spi_out_data,
  output logic queued_irq_served,
  output logic async_irq_served,
  output logic queued_halt,
  output logic module_stopped,
  output logic [sgi_pkg::PIN_COUNT-1:0] spi_in_data,
  output logic [sgi_pkg::PIN_COUNT-1:0] spi_in_enable,
  // pins
  input wire logic [sgi_pkg::PIN_COUNT-1:0] pin_in,
  output logic [sgi_pkg::PIN_COUNT-1:0] pin_out,
  output logic [sgi_pkg::PIN_COUNT-1:0] pin_oe_n
);
  import sgi_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ARB, ST_RESP, ST_DONE} sgi_ack_state_t;

  logic [DATA_W-1:0] config_r;
  logic [DATA_W-1:0] level_r;
  logic [7:1] vector_r;
  logic [DATA_W-1:0] port_data_r;
  logic [DATA_W-1:0] assign_r;
  logic [DATA_W-1:0] dir_r;
  logic [DATA_W-1:0] rdata_r;
  logic ack_r;
  logic [PIN_COUNT-1:0] pin_meta_r;
  logic [PIN_COUNT-1:0] pin_sync_r;
  logic stop;
  logic [LEVEL_W-1:0] queued_level;
  logic [LEVEL_W-1:0] async_level;
  logic [ARB_W-1:0] arb_number;
  logic [7:0] irq_lines;
  logic [7:1] irq_r;
  logic halt_r;
  sgi_ack_state_t state_r;
  logic [1:0] arb_cnt_r;
  logic arb_in_r;
  logic arb_out_r;
  logic src_queued_r;
  logic vec_valid_r;
  logic [7:0] vec_r;
  logic q_served_r;
  logic a_served_r;
  logic q_match;
  logic a_match;
  logic contend;
  logic arb_in_nxt;
  logic [PIN_COUNT-1:0] drive_nxt;
  logic [PIN_COUNT-1:0] value_nxt;
  logic [PIN_COUNT-1:0] in_en_nxt;
  logic [PIN_COUNT-1:0] pin_out_r;
  logic [PIN_COUNT-1:0] pin_oe_n_r;
  logic [PIN_COUNT-1:0] spi_in_r;
  logic [PIN_COUNT-1:0] spi_in_en_r;
  logic [PIN_COUNT-1:0] spi_out_pad;

  assign stop = config_r[CFG_STOP_BIT];
  assign queued_level = level_r[LVL_QUEUED_LSB +: LEVEL_W];
  assign async_level = level_r[LVL_ASYNC_LSB +: LEVEL_W];
  assign arb_number = config_r[CFG_ARB_LSB +: ARB_W];
  // pin 7 has no queued data; padded so every pin indexes in range
  assign spi_out_pad = {1'b0, spi_out_data};

  // register writes land regardless of stop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      config_r <= CONFIG_RESET; // [RULE4]
      level_r <= LEVEL_RESET;
      vector_r <= VECTOR_RESET[7:1]; // [RULE15]
      port_data_r <= PORT_DATA_RESET;
      assign_r <= PIN_ASSIGN_RESET;
      dir_r <= DIRECTION_RESET;
    end
    else if (bus.sel && bus.wr)
    begin
      case (bus.addr) // [RULE3]
        REG_CONFIG: config_r <= bus.wdata; // [RULE4]
        REG_LEVEL: level_r <= bus.wdata & 8'h3f;
        REG_VECTOR: vector_r <= bus.wdata[7:1]; // [RULE15]
        REG_PORT_DATA: port_data_r <= bus.wdata; // [RULE19]
        REG_PIN_ASSIGN: assign_r <= bus.wdata;
        REG_DIRECTION: dir_r <= bus.wdata;
        default: config_r <= config_r;
      endcase
    end
  end

  // reads answer one cycle later; while stopped only config is served
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= bus.sel;
      rdata_r <= 8'h00;
      if (bus.sel && !bus.wr)
      begin
        if (bus.addr == REG_CONFIG)
          rdata_r <= config_r;
        else if (!stop) // [RULE2]
        begin
          case (bus.addr)
            REG_LEVEL: rdata_r <= level_r;
            REG_VECTOR: rdata_r <= {vector_r, 1'b1}; // [RULE15]
            REG_PORT_DATA: rdata_r <= pin_sync_r; // [RULE19]
            REG_PIN_ASSIGN: rdata_r <= assign_r;
            REG_DIRECTION: rdata_r <= dir_r;
            default: rdata_r <= 8'h00;
          endcase
        end
      end
    end
  end

  // pin synchroniser
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // request lines; frozen state of a stopped module asserts nothing
  always_comb
  begin
    irq_lines = 8'h00;
    if (!stop && queued_irq_req && queued_level != 3'h0) // [RULE9]
      irq_lines[queued_level] = 1'b1; // [RULE8]
    if (!stop && async_irq_req && async_level != 3'h0) // [RULE9]
      irq_lines[async_level] = 1'b1; // [RULE8]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= '0;
    else
      irq_r <= irq_lines[7:1]; // [RULE1]
  end

  // queued unit halt on freeze, taken at a transfer boundary
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      halt_r <= 1'b0;
    else if (!bus.freeze)
      halt_r <= 1'b0;
    else if (!stop && config_r[CFG_FRZ1_BIT] && transfer_boundary) // [RULE6]
      halt_r <= 1'b1;
  end

  // acknowledge: compare mask, contend serially, then answer with vector
  assign q_match = queued_irq_req && queued_level != 3'h0 && queued_level == bus.iack_level;
  assign a_match = async_irq_req && async_level != 3'h0 && async_level == bus.iack_level;
  assign contend = !stop && (q_match || a_match) && (bus.iack_level > bus.iack_mask); // [RULE11]
  assign arb_in_nxt = arb_in_r && !(bus.arb_bus && !arb_out_r); // [RULE12]

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= ST_IDLE;
      arb_cnt_r <= 2'h0;
      arb_in_r <= 1'b0;
      arb_out_r <= 1'b0;
      src_queued_r <= 1'b0;
      vec_valid_r <= 1'b0;
      vec_r <= 8'h00;
      q_served_r <= 1'b0;
      a_served_r <= 1'b0;
    end
    else
    begin
      q_served_r <= 1'b0;
      a_served_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          if (bus.iack && contend)
          begin
            state_r <= ST_ARB;
            arb_cnt_r <= 2'h3;
            arb_in_r <= 1'b1;
            arb_out_r <= arb_number[ARB_W-1];
            src_queued_r <= q_match; // [RULE10]
          end
          else if (bus.iack)
            state_r <= ST_DONE;
        ST_ARB:
        begin
          arb_in_r <= arb_in_nxt; // [RULE12]
          if (arb_cnt_r == 2'h0)
          begin
            state_r <= ST_RESP;
            arb_out_r <= 1'b0;
          end
          else
          begin
            arb_cnt_r <= arb_cnt_r - 2'h1;
            arb_out_r <= arb_number[arb_cnt_r - 2'h1] & arb_in_nxt;
          end
        end
        ST_RESP:
        begin
          state_r <= ST_DONE;
          if (arb_in_r && arb_number != 4'h0) // [RULE12]
          begin
            vec_valid_r <= 1'b1; // [RULE13]
            vec_r <= {vector_r, src_queued_r}; // [RULE14]
            q_served_r <= src_queued_r;
            a_served_r <= !src_queued_r;
          end
        end
        ST_DONE:
          if (!bus.iack)
          begin
            state_r <= ST_IDLE;
            vec_valid_r <= 1'b0;
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // per-pin function selection
  for (genvar i = 0; i < PIN_COUNT; i++)
  begin : g_pin
    always_comb
    begin
      drive_nxt[i] = dir_r[i]; // [RULE17]
      value_nxt[i] = port_data_r[i]; // [RULE19]
      in_en_nxt[i] = 1'b0;
      if (i == PIN_TXD)
      begin
        if (async_tx_enable) // [RULE18]
        begin
          drive_nxt[i] = 1'b1;
          value_nxt[i] = txd_data;
        end
      end
      else if (assign_r[i] && (i != PIN_SCK || queued_unit_enable)) // [RULE16] [RULE23]
      begin
        value_nxt[i] = spi_out_pad[i];
        if (i == PIN_MISO)
        begin
          drive_nxt[i] = !master_mode && dir_r[i]; // [RULE21]
          in_en_nxt[i] = master_mode && !dir_r[i];
        end
        else if (i == PIN_MOSI)
        begin
          drive_nxt[i] = master_mode && dir_r[i]; // [RULE21]
          in_en_nxt[i] = !master_mode && !dir_r[i];
        end
        else if (i == PIN_SCK)
        begin
          drive_nxt[i] = master_mode;
          in_en_nxt[i] = !master_mode;
        end
        else
        begin
          drive_nxt[i] = master_mode && dir_r[i]; // [RULE22]
          in_en_nxt[i] = (i == PIN_SEL0) && !dir_r[i];
        end
      end
    end
  end

  // pins hold their last state while the module clock is off
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out_r <= '0;
      pin_oe_n_r <= '1;
      spi_in_r <= '0;
      spi_in_en_r <= '0;
    end
    else if (!stop) // [RULE1]
    begin
      pin_out_r <= value_nxt;
      pin_oe_n_r <= ~drive_nxt;
      spi_in_r <= pin_sync_r;
      spi_in_en_r <= in_en_nxt;
    end
  end

  assign bus.rdata = rdata_r;
  assign bus.ack = ack_r;
  assign bus.irq_req = irq_r;
  assign bus.arb_out = arb_out_r;
  assign bus.vec_valid = vec_valid_r;
  assign bus.vector = vec_r;
  assign queued_irq_served = q_served_r;
  assign async_irq_served = a_served_r;
  assign queued_halt = halt_r;
  assign module_stopped = stop;
  assign spi_in_data = spi_in_r;
  assign spi_in_enable = spi_in_en_r;
  assign pin_out = pin_out_r;
  assign pin_oe_n = pin_oe_n_r;
endmodule : sgi_device
`default_nettype wire

// [hdl/sgi_host.sv]
// core end: register access, freeze drive and interrupt acknowledge cycles
`timescale 1ns/1ns
`default_nettype none
module sgi_host (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // link to the module
  sgi_if.host bus,
  // register requests
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [sgi_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [sgi_pkg::DATA_W-1:0] reg_wdata,
  output logic [sgi_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_done,
  // acknowledge requests
  input wire logic iack_start,
  input wire logic [sgi_pkg::LEVEL_W-1:0] iack_level_in,
  input wire logic [sgi_pkg::LEVEL_W-1:0] iack_mask_in,
  output logic [7:0] iack_vector,
  output logic iack_spurious,
  output logic iack_done,
  // debug
  input wire logic debug_mode
);
  import sgi_pkg::*;

  typedef enum logic [1:0] {HS_IDLE, HS_REG, HS_IACK, HS_END} sgi_host_state_t;

  sgi_host_state_t state_r;
  logic sel_r;
  logic wr_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] rdata_r;
  logic done_r;
  logic iack_r;
  logic [LEVEL_W-1:0] level_r;
  logic [LEVEL_W-1:0] mask_r;
  logic [3:0] wait_r;
  logic [7:0] vector_r;
  logic spurious_r;
  logic idone_r;
  logic freeze_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      freeze_r <= 1'b0;
    else
      freeze_r <= debug_mode; // [RULE7]
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= HS_IDLE;
      sel_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      done_r <= 1'b0;
      iack_r <= 1'b0;
      level_r <= '0;
      mask_r <= '0;
      wait_r <= 4'h0;
      vector_r <= 8'h00;
      spurious_r <= 1'b0;
      idone_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      idone_r <= 1'b0;
      sel_r <= 1'b0;
      case (state_r)
        HS_IDLE:
          if (reg_req)
          begin
            state_r <= HS_REG;
            sel_r <= 1'b1;
            wr_r <= reg_wr;
            addr_r <= reg_addr;
            wdata_r <= reg_wdata;
          end
          else if (iack_start)
          begin
            state_r <= HS_IACK;
            iack_r <= 1'b1;
            level_r <= iack_level_in;
            mask_r <= iack_mask_in; // [RULE11]
            wait_r <= 4'h0;
          end
        HS_REG:
          if (bus.ack)
          begin
            state_r <= HS_IDLE;
            rdata_r <= bus.rdata;
            done_r <= 1'b1;
          end
        HS_IACK:
        begin
          wait_r <= wait_r + 4'h1;
          if (bus.vec_valid)
          begin
            vector_r <= bus.vector; // [RULE13]
            spurious_r <= 1'b0;
            idone_r <= 1'b1;
            iack_r <= 1'b0;
            state_r <= HS_END;
          end
          else if (wait_r == IACK_TIMEOUT)
          begin
            vector_r <= 8'h00;
            spurious_r <= 1'b1; // [RULE12]
            idone_r <= 1'b1;
            iack_r <= 1'b0;
            state_r <= HS_END;
          end
        end
        HS_END:
          if (!bus.vec_valid)
            state_r <= HS_IDLE;
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  assign bus.sel = sel_r;
  assign bus.wr = wr_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.freeze = freeze_r;
  assign bus.iack = iack_r;
  assign bus.iack_level = level_r;
  assign bus.iack_mask = mask_r;
  // single contender, so the wired-or line is just its bit
  assign bus.arb_bus = bus.arb_out; // [RULE12]
  assign reg_rdata = rdata_r;
  assign reg_done = done_r;
  assign iack_vector = vector_r;
  assign iack_spurious = spurious_r;
  assign iack_done = idone_r;
endmodule : sgi_host
`default_nettype wire

// [sim/sgi_chk.sv]
// concurrent checks on the link between the core end and the module end
`timescale 1ns/1ns
`default_nettype none
module sgi_chk (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // register access
  input wire logic sel,
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack,
  // interrupts
  input wire logic [7:1] irq_req,
  input wire logic iack,
  input wire logic [2:0] iack_level,
  input wire logic [2:0] iack_mask,
  input wire logic vec_valid,
  input wire logic [7:0] vector
);
  import sgi_pkg::*;
  logic [7:0] cfg_r;
  logic [7:1] vec_r;
  logic [5:0] lvl_r;
  logic [7:0] lvl_mask;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadows of the written registers, so reads and vectors can be judged
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_r <= CONFIG_RESET;
    else if (sel && wr && addr == REG_CONFIG)
      cfg_r <= wdata;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      vec_r <= VECTOR_RESET[7:1];
    else if (sel && wr && addr == REG_VECTOR)
      vec_r <= wdata[7:1];
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lvl_r <= LEVEL_RESET[5:0];
    else if (sel && wr && addr == REG_LEVEL)
      lvl_r <= wdata[5:0];
  end
  assign lvl_mask = (8'h01 << lvl_r[5:3]) | (8'h01 << lvl_r[2:0]);
  chk_ack_follow: assert property (sel |=> ack) else $error("no ack after access");
  chk_ack_cause: assert property (ack |-> $past(sel)) else $error("ack without access");
  chk_cfg_read: assert property (sel && !wr && addr == REG_CONFIG |=> rdata == cfg_r) else $error("config read");
  chk_stop_blocks: assert property (sel && !wr && addr != REG_CONFIG && cfg_r[7] |=> rdata == 8'h00) else $error("read while stopped");
  chk_vec_read: assert property (sel && !wr && addr == REG_VECTOR && !cfg_r[7] |=> rdata == {vec_r, 1'b1}) else $error("vector read");
  chk_stop_quiet: assert property (cfg_r[7] [*3] |-> irq_req == 7'h00) else $error("request while stopped");
  chk_irq_lines: assert property (lvl_r == $past(lvl_r) && lvl_r == $past(lvl_r, 2) |-> (irq_req & ~lvl_mask[7:1]) == 7'h00) else $error("wrong request line");
  chk_vec_upper: assert property (vec_valid |-> vector[7:1] == vec_r) else $error("vector upper bits");
  chk_vec_timing: assert property ($rose(vec_valid) |-> $past(iack, 6) && !$past(iack, 7)) else $error("vector timing");
  chk_vec_stands: assert property (vec_valid && iack |=> vec_valid && $stable(vector)) else $error("vector not held");
  chk_vec_release: assert property ($fell(iack) |=> !vec_valid) else $error("vector not released");
  chk_arb_nonzero: assert property ($rose(vec_valid) |-> cfg_r[3:0] != 4'h0) else $error("answer with zero number");
  chk_mask_below: assert property ($rose(vec_valid) |-> iack_level > iack_mask) else $error("answer at masked level");
endmodule : sgi_chk
`default_nettype wire

// [sim/test_serial_module_global_irq_pins.sv]
// bench: both link ends joined and compared with a register and interrupt model
`timescale 1ns/1ns
`default_nettype none
module test_serial_module_global_irq_pins;
  import sgi_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic qreq = 1'b0, areq = 1'b0, qen = 1'b0, txen = 1'b0, mst = 1'b0, tbound = 1'b0, txd = 1'b0;
  logic dbg = 1'b0, rreq = 1'b0, rwr = 1'b0, istart = 1'b0;
  logic [3:0] raddr = 4'h0;
  logic [7:0] rwd = 8'h00, ext = 8'h00, rrd, ivec, pin_out, pin_oe_n, spi_in, spi_in_en;
  logic [6:0] spi_out = 7'h00;
  logic [2:0] ilvl = 3'h0, imask = 3'h0;
  logic rdone, idone, ispur, qserved, aserved, qhalt, stopped;
  wire logic [7:0] pin_in;
  logic [7:0] mreg [0:5];
  logic [31:0] seed = 32'h00006f61;
  int errors = 0;
  int tests_run = 0;
  sgi_if bus_if ();
  // a driven pin reads back its own level, an undriven one the outside level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
  always #2 clk = ~clk;
  sgi_device u_sgi_device (.clk(clk), .reset_n(reset_n), .bus(bus_if), .queued_irq_req(qreq),
    .async_irq_req(areq), .queued_unit_enable(qen), .async_tx_enable(txen), .master_mode(mst),
    .transfer_boundary(tbound), .txd_data(txd), .spi_out_data(spi_out), .queued_irq_served(qserved),
    .async_irq_served(aserved), .queued_halt(qhalt), .module_stopped(stopped), .spi_in_data(spi_in),
    .spi_in_enable(spi_in_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  sgi_host u_sgi_host (.clk(clk), .reset_n(reset_n), .bus(bus_if), .reg_req(rreq), .reg_wr(rwr),
    .reg_addr(raddr), .reg_wdata(rwd), .reg_rdata(rrd), .reg_done(rdone), .iack_start(istart),
    .iack_level_in(ilvl), .iack_mask_in(imask), .iack_vector(ivec), .iack_spurious(ispur),
    .iack_done(idone), .debug_mode(dbg));
  sgi_chk u_sgi_chk (.clk(clk), .reset_n(reset_n), .sel(bus_if.sel), .wr(bus_if.wr), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .ack(bus_if.ack), .irq_req(bus_if.irq_req),
    .iack(bus_if.iack), .iack_level(bus_if.iack_level), .iack_mask(bus_if.iack_mask),
    .vec_valid(bus_if.vec_valid), .vector(bus_if.vector));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_rd(input logic [3:0] a);
    if (a > 4'h5 || (mreg[0][7] && a != REG_CONFIG))
      return 8'h00;
    // pin levels are only predictable with every pin in general use
    if (a == REG_PORT_DATA)
      return (mreg[3] & mreg[5]) | (ext & ~mreg[5]);
    return mreg[a];
  endfunction : exp_rd
  function automatic logic [7:0] exp_irq();
    logic [7:0] e = 8'h00;
    if (qreq && !mreg[0][7])
      e = e | (8'h01 << mreg[1][5:3]);
    if (areq && !mreg[0][7])
      e = e | (8'h01 << mreg[1][2:0]);
    return e & 8'hfe;
  endfunction : exp_irq
  task automatic model_reset();
    mreg = '{CONFIG_RESET, LEVEL_RESET, VECTOR_RESET, PORT_DATA_RESET, PIN_ASSIGN_RESET, DIRECTION_RESET};
  endtask : model_reset
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic reg_op(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(negedge clk);
    rreq = 1'b1;
    rwr = w;
    raddr = a;
    rwd = d;
    // held until done: the core end only takes a request while idle
    for (n = 0; n < 20 && rdone !== 1'b1; n++) @(negedge clk);
    rreq = 1'b0;
    if (rdone !== 1'b1)
      errors++;
    r = rrd;
  endtask : reg_op
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    reg_op(1'b1, a, d, r);
    if (a == REG_VECTOR)
      mreg[2] = {d[7:1], 1'b1};
    else if (a == REG_LEVEL)
      mreg[1] = d & 8'h3f;
    else if (a < 4'h6)
      mreg[a] = d;
  endtask : wr
  task automatic rd_all();
    logic [7:0] r;
    for (int a = 0; a < 7; a++)
    begin
      reg_op(1'b0, a[3:0], 8'h00, r);
      check(r, exp_rd(a[3:0]));
    end
  endtask : rd_all
  task automatic iack_run(input logic [2:0] l, input logic [2:0] m);
    logic q, a, sp, qsv, asv;
    int n;
    q = qreq && mreg[1][5:3] == l;
    a = areq && mreg[1][2:0] == l;
    sp = !(l != 3'h0 && l > m && mreg[0][3:0] != 4'h0 && !mreg[0][7] && (q || a));
    qsv = 1'b0;
    asv = 1'b0;
    @(negedge clk);
    istart = 1'b1;
    ilvl = l;
    imask = m;
    // held until done: a start during the previous cycle's tail is not taken
    for (n = 0; n < 30 && idone !== 1'b1; n++)
    begin
      @(negedge clk);
      qsv = qsv | qserved;
      asv = asv | aserved;
    end
    istart = 1'b0;
    if (idone !== 1'b1)
      errors++;
    check({7'h00, ispur}, {7'h00, sp});
    check({6'h00, qsv, asv}, {6'h00, q && !sp, !q && !sp});
    if (!sp)
      check(ivec, {mreg[2][7:1], q});
  endtask : iack_run
  task automatic freeze_try(input logic [7:0] c, input logic h);
    wr(REG_CONFIG, c);
    dbg = 1'b1;
    repeat (3) @(negedge clk);
    tbound = 1'b1;
    @(negedge clk);
    tbound = 1'b0;
    repeat (2) @(negedge clk);
    check({7'h00, qhalt}, {7'h00, h});
    dbg = 1'b0;
    repeat (4) @(negedge clk);
    check({7'h00, qhalt}, 8'h00);
  endtask : freeze_try
  initial
  begin
    #200000;
    errors++;
    final_report();
  end
  initial
  begin
    logic [31:0] x;
    logic [7:0] r;
    model_reset();
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    rd_all();
    wr(REG_CONFIG, 8'h05);
    rd_all();
    // stored while stopped, visible once running again
    wr(REG_CONFIG, 8'h85);
    wr(REG_VECTOR, 8'h50);
    wr(REG_LEVEL, 8'hed);
    wr(REG_CONFIG, 8'h05);
    rd_all();
    for (int i = 0; i < 24; i++)
    begin
      x = rnd();
      wr(REG_LEVEL, x[7:0]);
      qreq = x[8];
      areq = x[9];
      repeat (3) @(negedge clk);
      check({bus_if.irq_req, 1'b0}, exp_irq());
      iack_run(x[10] ? x[5:3] : x[2:0], x[11] ? 3'h0 : x[14:12]);
    end
    wr(REG_LEVEL, 8'h2d);
    qreq = 1'b1;
    areq = 1'b1;
    iack_run(3'h5, 3'h4);
    qreq = 1'b0;
    iack_run(3'h5, 3'h1);
    wr(REG_CONFIG, 8'h00);
    iack_run(3'h5, 3'h1);
    freeze_try(8'h45, 1'b1);
    freeze_try(8'h25, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      x = rnd();
      ext = x[23:16];
      txd = x[24];
      spi_out = x[31:25];
      wr(REG_PORT_DATA, x[7:0]);
      wr(REG_DIRECTION, x[15:8]);
      repeat (2) @(negedge clk);
      check(pin_oe_n, ~mreg[5]);
      check(pin_out & mreg[5], mreg[3] & mreg[5]);
      reg_op(1'b0, REG_PORT_DATA, 8'h00, r);
      check(r, exp_rd(REG_PORT_DATA));
      check(spi_in, exp_rd(REG_PORT_DATA));
    end
    txen = 1'b1;
    wr(REG_DIRECTION, 8'h00);
    repeat (2) @(negedge clk);
    check({6'h00, pin_oe_n[7], pin_out[7]}, {7'h00, txd});
    wr(REG_PIN_ASSIGN, 8'hff);
    mst = 1'b1;
    repeat (2) @(negedge clk);
    check({3'h0, pin_oe_n[2], spi_in_en[3:0]}, 8'h19);
    qen = 1'b1;
    wr(REG_DIRECTION, 8'h0f);
    repeat (2) @(negedge clk);
    check({1'b0, pin_oe_n[3:1], spi_in_en[3:0]}, 8'h00);
    mst = 1'b0;
    wr(REG_DIRECTION, 8'h00);
    repeat (2) @(negedge clk);
    check({4'h0, spi_in_en[3:0]}, 8'h0e);
    qreq = 1'b1;
    wr(REG_LEVEL, 8'h18);
    wr(REG_CONFIG, 8'h85);
    repeat (3) @(negedge clk);
    check({bus_if.irq_req, 1'b0}, 8'h00);
    check({7'h00, stopped}, 8'h01);
    rd_all();
    @(negedge clk);
    reset_n = 1'b0;
    model_reset();
    repeat (2) @(negedge clk);
    check(pin_oe_n, 8'hff);
    reset_n = 1'b1;
    rd_all();
    final_report();
  end
endmodule : test_serial_module_global_irq_pins
`default_nettype wire
